// ==== eeec_edge_catch.sv ====
// One edge line: asynchronous edge capture, synchroniser and trigger select
`timescale 1ns/1ps
module eeec_edge_catch
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_in,
	input wire logic rise_en,
	input wire logic fall_en,
	output logic edge_hit
);
	logic rise_tog;
	logic fall_tog;
	logic [2:0] rise_sync;
	logic [2:0] fall_sync;
	logic next_edge_hit;

	// The line itself clocks these, so pulses narrower than clk are held
	always_ff @(posedge line_in or negedge rst_n)
	begin
		if (!rst_n)
			rise_tog <= 1'b0;
		else
			rise_tog <= ~rise_tog;
	end

	always_ff @(negedge line_in or negedge rst_n)
	begin
		if (!rst_n)
			fall_tog <= 1'b0;
		else
			fall_tog <= ~fall_tog;
	end

	always_comb
	begin
		next_edge_hit = ((rise_sync[2] ^ rise_sync[1]) & rise_en)
			| ((fall_sync[2] ^ fall_sync[1]) & fall_en);
	end

	// Stage 0 is read only by stage 1; stages 1 and 2 form the detector
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rise_sync <= 3'h0;
			fall_sync <= 3'h0;
			edge_hit <= 1'b0;
		end
		else
		begin
			rise_sync <= {rise_sync[1:0], rise_tog};
			fall_sync <= {fall_sync[1:0], fall_tog};
			edge_hit <= next_edge_hit;
		end
	end

	rise_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rise_en && (rise_sync[2] != rise_sync[1])) |=> edge_hit)
		else $error("captured rising edge not reported");
	trig_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!rise_en && !fall_en) |=> !edge_hit)
		else $error("edge reported with both triggers off");
endmodule

// ==== eeec_irq_sink.sv ====
// Far side model: interrupt controller counting event and wake pulses
`timescale 1ns/1ps
module eeec_irq_sink
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [eeec_pkg::LINES-1:0] evt_req,
	input wire logic wake_req,
	output logic [15:0] evt_total,
	output logic [15:0] wake_total
);
	logic [15:0] next_evt_total;
	logic [15:0] next_wake_total;

	always_comb
	begin
		next_evt_total = evt_total + 16'($countones(evt_req));
		next_wake_total = wake_total + {15'h0000, wake_req};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_total <= 16'h0000;
			wake_total <= 16'h0000;
		end
		else
		begin
			evt_total <= next_evt_total;
			wake_total <= next_wake_total;
		end
	end
endmodule

// ==== eeec_pin_select.sv ====
// Source selection of the pin lines from the general pins
`timescale 1ns/1ps
module eeec_pin_select
#(
	parameter int PORTS = eeec_pkg::PORTS,
	parameter int PIN_LINES = eeec_pkg::PIN_LINES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [PORTS*PIN_LINES-1:0] pins,
	input wire logic [PIN_LINES*eeec_pkg::SEL_W-1:0] port_sel,
	output logic [PIN_LINES-1:0] line_src
);
	genvar i;
	generate
		for (i = 0; i < PIN_LINES; i++)
		begin : g_line
			logic [eeec_pkg::SEL_W-1:0] sel;
			logic [PORTS-1:0] cand;
			assign sel = port_sel[i*eeec_pkg::SEL_W +: eeec_pkg::SEL_W];
			// Candidate p is pin n of port p
			for (genvar p = 0; p < PORTS; p++)
			begin : g_port
				assign cand[p] = pins[p*PIN_LINES + i];
			end
			// One pin only; an out of range choice gives a quiet low line
			assign line_src[i] = (int'(sel) < PORTS) ? cand[sel] : 1'b0;
			sel_range_a: assert property (@(posedge clk) disable iff (!rst_n)
				(int'(sel) >= PORTS) |-> !line_src[i])
				else $error("missing port did not give a low line");
		end
	endgenerate
endmodule

// ==== eeec_pkg.sv ====
// Constants, register map and carrier types of the edge event unit
// Functional notes
// - Nineteen edge lines, each raising interrupt and event requests.
// - Per line trigger choice: rising only, falling only, or both edges.
// - Per line interrupt and event masks; a line masked in both forwards nothing, other lines unaffected.
// - A detected trigger sets a pending bit until software clears it.
// - Sub-period pulses are latched asynchronously, then synchronised.
// - Sixteen lines fed from general pins; eighty pins are selectable.
// - Remaining lines: supply voltage monitor, calendar alarm, USB wake-up.
// - A valid trigger on any line can wake the device from stop.
package eeec_pkg;
	localparam int LINES = 19;
	localparam int PIN_LINES = 16;
	localparam int PORTS = 5;
	localparam int SEL_W = 3;
	localparam int LINE_SUPPLY = 16;
	localparam int LINE_ALARM = 17;
	localparam int LINE_USB = 18;
	localparam int SEL_FIELD_W = 4;
	localparam int SEL_PER_REG = 8;
	// Byte offsets of the registers
	localparam logic [7:0] OFF_INT_MASK = 8'h00;
	localparam logic [7:0] OFF_EVT_MASK = 8'h04;
	localparam logic [7:0] OFF_RISE_EN = 8'h08;
	localparam logic [7:0] OFF_FALL_EN = 8'h0c;
	localparam logic [7:0] OFF_SOFT_TRIG = 8'h10;
	localparam logic [7:0] OFF_PENDING = 8'h14;
	localparam logic [7:0] OFF_PORT_SEL0 = 8'h18;
	localparam logic [7:0] OFF_PORT_SEL1 = 8'h1c;
	// Values after reset
	localparam logic [18:0] RST_LINE_VEC = 19'h00000;
	localparam logic [31:0] RST_PORT_SEL = 32'h00000000;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} eeec_wb_req_type;
endpackage

// ==== eeec_top.sv ====
// Edge event unit: nineteen lines, masks, pending flags, Wishbone slave
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module eeec_top
#(
	parameter int PORTS = eeec_pkg::PORTS,
	parameter int PIN_LINES = eeec_pkg::PIN_LINES
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [PORTS*PIN_LINES-1:0] GENERAL_PINS,
	input wire logic SUPPLY_MON,
	input wire logic CAL_ALARM,
	input wire logic USB_WAKE,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic [eeec_pkg::LINES-1:0] IRQ_REQ,
	output logic [eeec_pkg::LINES-1:0] EVT_REQ,
	output logic WAKE_REQ
);
	localparam int N = eeec_pkg::LINES;
	localparam int SW = eeec_pkg::SEL_W;

	logic [eeec_pkg::SYNC_STAGES-1:0] rst_pipe;
	logic rst_n;
	eeec_pkg::eeec_wb_req_type req;

	logic [N-1:0] int_mask;
	logic [N-1:0] evt_mask;
	logic [N-1:0] rise_en;
	logic [N-1:0] fall_en;
	logic [N-1:0] pending;
	logic [31:0] port_sel0;
	logic [31:0] port_sel1;
	logic [N-1:0] next_int_mask;
	logic [N-1:0] next_evt_mask;
	logic [N-1:0] next_rise_en;
	logic [N-1:0] next_fall_en;
	logic [N-1:0] next_pending;
	logic [31:0] next_port_sel0;
	logic [31:0] next_port_sel1;
	logic [31:0] next_dat;
	logic next_ack;
	logic [N-1:0] next_irq;
	logic [N-1:0] next_evt;
	logic next_wake;

	logic [N-1:0] line_in;
	logic [N-1:0] edge_vec;
	logic [N-1:0] soft_set;
	logic [N-1:0] clr_vec;
	logic [PIN_LINES*SW-1:0] sel_flat;
	logic [31:0] bmask;
	logic take;
	logic wr;

	// Reset is released through two flip-flops
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			rst_pipe <= '0;
		else
			rst_pipe <= {rst_pipe[eeec_pkg::SYNC_STAGES-2:0], 1'b1};
	end
	assign rst_n = rst_pipe[eeec_pkg::SYNC_STAGES-1];

	assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
		adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

	// Eight select fields per register: 4 bits each, low 3 used
	genvar k;
	generate
		for (k = 0; k < PIN_LINES; k++)
		begin : g_sel
			if (k < eeec_pkg::SEL_PER_REG)
			begin : g_lo
				assign sel_flat[k*SW +: SW] =
					port_sel0[k*eeec_pkg::SEL_FIELD_W +: SW];
			end
			else
			begin : g_hi
				assign sel_flat[k*SW +: SW] = port_sel1[
					(k-eeec_pkg::SEL_PER_REG)*eeec_pkg::SEL_FIELD_W +: SW];
			end
		end
	endgenerate

	eeec_pin_select #(
		.PORTS(PORTS),
		.PIN_LINES(PIN_LINES)
	) u_pin_select (
		.clk(CLK),
		.rst_n(rst_n),
		.pins(GENERAL_PINS),
		.port_sel(sel_flat),
		.line_src(line_in[PIN_LINES-1:0])
	);

	assign line_in[eeec_pkg::LINE_SUPPLY] = SUPPLY_MON;
	assign line_in[eeec_pkg::LINE_ALARM] = CAL_ALARM;
	assign line_in[eeec_pkg::LINE_USB] = USB_WAKE;

	generate
		for (k = 0; k < N; k++)
		begin : g_line
			eeec_edge_catch u_catch (
				.clk(CLK),
				.rst_n(rst_n),
				.line_in(line_in[k]),
				.rise_en(rise_en[k]),
				.fall_en(fall_en[k]),
				.edge_hit(edge_vec[k])
			);
		end
	endgenerate

	// Register slave: answer one cycle after the request is seen
	assign take = req.cyc & req.stb & ~WB_ACK_O;
	assign wr = take & req.we;
	assign bmask = {{8{req.sel[3]}}, {8{req.sel[2]}},
		{8{req.sel[1]}}, {8{req.sel[0]}}};
	assign soft_set = (wr && req.adr == eeec_pkg::OFF_SOFT_TRIG)
		? req.dat[N-1:0] & bmask[N-1:0] : '0;
	assign clr_vec = (wr && req.adr == eeec_pkg::OFF_PENDING)
		? req.dat[N-1:0] & bmask[N-1:0] : '0;

	always_comb
	begin
		next_int_mask = int_mask;
		next_evt_mask = evt_mask;
		next_rise_en = rise_en;
		next_fall_en = fall_en;
		next_port_sel0 = port_sel0;
		next_port_sel1 = port_sel1;
		next_dat = 32'h00000000;
		next_ack = take;
		if (wr)
		begin
			case (req.adr)
				eeec_pkg::OFF_INT_MASK:
					next_int_mask = (int_mask & ~bmask[N-1:0])
						| (req.dat[N-1:0] & bmask[N-1:0]);
				eeec_pkg::OFF_EVT_MASK:
					next_evt_mask = (evt_mask & ~bmask[N-1:0])
						| (req.dat[N-1:0] & bmask[N-1:0]);
				eeec_pkg::OFF_RISE_EN:
					next_rise_en = (rise_en & ~bmask[N-1:0])
						| (req.dat[N-1:0] & bmask[N-1:0]);
				eeec_pkg::OFF_FALL_EN:
					next_fall_en = (fall_en & ~bmask[N-1:0])
						| (req.dat[N-1:0] & bmask[N-1:0]);
				eeec_pkg::OFF_PORT_SEL0:
					next_port_sel0 = (port_sel0 & ~bmask) | (req.dat & bmask);
				eeec_pkg::OFF_PORT_SEL1:
					next_port_sel1 = (port_sel1 & ~bmask) | (req.dat & bmask);
				default:
					next_ack = take;
			endcase
		end
		else if (take)
		begin
			case (req.adr)
				eeec_pkg::OFF_INT_MASK: next_dat = {13'h0000, int_mask};
				eeec_pkg::OFF_EVT_MASK: next_dat = {13'h0000, evt_mask};
				eeec_pkg::OFF_RISE_EN: next_dat = {13'h0000, rise_en};
				eeec_pkg::OFF_FALL_EN: next_dat = {13'h0000, fall_en};
				eeec_pkg::OFF_PENDING: next_dat = {13'h0000, pending};
				eeec_pkg::OFF_PORT_SEL0: next_dat = port_sel0;
				eeec_pkg::OFF_PORT_SEL1: next_dat = port_sel1;
				default: next_dat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			int_mask <= eeec_pkg::RST_LINE_VEC;
			evt_mask <= eeec_pkg::RST_LINE_VEC;
			rise_en <= eeec_pkg::RST_LINE_VEC;
			fall_en <= eeec_pkg::RST_LINE_VEC;
			port_sel0 <= eeec_pkg::RST_PORT_SEL;
			port_sel1 <= eeec_pkg::RST_PORT_SEL;
			WB_DAT_O <= 32'h00000000;
			WB_ACK_O <= 1'b0;
		end
		else
		begin
			int_mask <= next_int_mask;
			evt_mask <= next_evt_mask;
			rise_en <= next_rise_en;
			fall_en <= next_fall_en;
			port_sel0 <= next_port_sel0;
			port_sel1 <= next_port_sel1;
			WB_DAT_O <= next_dat;
			WB_ACK_O <= next_ack;
		end
	end

	// Pending flags and request outputs; a new edge beats a clear
	always_comb
	begin
		next_pending = (pending & ~clr_vec) | edge_vec | soft_set;
		next_irq = pending & int_mask;
		next_evt = (edge_vec | soft_set) & evt_mask;
		next_wake = |((edge_vec | soft_set) & (int_mask | evt_mask));
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pending <= eeec_pkg::RST_LINE_VEC;
			IRQ_REQ <= eeec_pkg::RST_LINE_VEC;
			EVT_REQ <= eeec_pkg::RST_LINE_VEC;
			WAKE_REQ <= 1'b0;
		end
		else
		begin
			pending <= next_pending;
			IRQ_REQ <= next_irq;
			EVT_REQ <= next_evt;
			WAKE_REQ <= next_wake;
		end
	end

	pend_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(edge_vec != '0) |=> ((pending & $past(edge_vec)) == $past(edge_vec)))
		else $error("edge did not set its pending bit");
	pend_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(clr_vec == '0) |=> ((pending & $past(pending)) == $past(pending)))
		else $error("pending bit dropped without a clear");
	irq_follow_a: assert property (@(posedge CLK) disable iff (!rst_n)
		1'b1 |=> ((IRQ_REQ & ~$past(int_mask)) == '0))
		else $error("masked line raised an interrupt");
	irq_rise_a: assert property (@(posedge CLK) disable iff (!rst_n)
		((edge_vec & int_mask) != '0) |=> ##1
		((IRQ_REQ & $past(edge_vec & int_mask, 2)) != '0))
		else $error("enabled edge gave no interrupt request");
	evt_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
		((edge_vec & evt_mask) != '0) |=>
		((EVT_REQ & $past(edge_vec & evt_mask)) == $past(edge_vec & evt_mask)))
		else $error("enabled edge gave no event pulse");
	wake_on_a: assert property (@(posedge CLK) disable iff (!rst_n)
		((edge_vec & (int_mask | evt_mask)) != '0) |=> WAKE_REQ)
		else $error("enabled edge gave no wake request");
	ack_single_a: assert property (@(posedge CLK) disable iff (!rst_n)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge held for two cycles");

	// Bus answer timing and idle read data
	ack_after_req_a: assert property (@(posedge CLK) disable iff (!rst_n)
		take |=> WB_ACK_O)
		else $error("request not acknowledged next cycle");
	ack_no_req_a: assert property (@(posedge CLK) disable iff (!rst_n)
		!(req.cyc && req.stb) |=> !WB_ACK_O)
		else $error("acknowledge without a request");
	dat_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
		!WB_ACK_O |-> (WB_DAT_O == 32'h00000000))
		else $error("read data driven outside acknowledge");
	mask_write_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(wr && req.adr == eeec_pkg::OFF_INT_MASK && req.sel == 4'hf)
		|=> (int_mask == $past(req.dat[N-1:0])))
		else $error("interrupt mask write lost");
	read_pend_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(take && !req.we && req.adr == eeec_pkg::OFF_PENDING)
		|=> (WB_DAT_O == {13'h0000, $past(pending)}))
		else $error("pending read returned wrong flags");
	soft_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(take && !req.we && req.adr == eeec_pkg::OFF_SOFT_TRIG)
		|=> (WB_DAT_O == 32'h00000000))
		else $error("soft trigger register did not read zero");

	// Pending flag causes
	soft_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(soft_set != '0)
		|=> ((pending & $past(soft_set)) == $past(soft_set)))
		else $error("soft trigger did not set pending");
	clr_drop_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(clr_vec != '0 && edge_vec == '0 && soft_set == '0)
		|=> ((pending & $past(clr_vec)) == '0))
		else $error("cleared pending bit stayed set");
	pend_cause_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(edge_vec == '0 && soft_set == '0)
		|=> ((pending & ~$past(pending)) == '0))
		else $error("pending bit set without a trigger");

	// Event and wake outputs
	evt_masked_a: assert property (@(posedge CLK) disable iff (!rst_n)
		1'b1 |=> ((EVT_REQ & ~$past(evt_mask)) == '0))
		else $error("masked line raised an event");
	evt_only_edge_a: assert property (@(posedge CLK) disable iff (!rst_n)
		((edge_vec | soft_set) == '0) |=> (EVT_REQ == '0))
		else $error("event pulse without a trigger");
	wake_quiet_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(((edge_vec | soft_set) & (int_mask | evt_mask)) == '0)
		|=> !WAKE_REQ)
		else $error("wake request without an enabled trigger");
endmodule

// ==== external_edge_event_controller_test.sv ====
// Self-checking bench of the edge event unit
`timescale 1ns/1ps
module external_edge_event_controller_test;
	logic CLK;
	logic RST_N;
	logic [79:0] pins;
	logic sup;
	logic cal;
	logic usb;
	eeec_pkg::eeec_wb_req_type req;
	logic [31:0] rdat;
	logic ack;
	logic [18:0] irq;
	logic [18:0] evt;
	logic wake;
	logic [15:0] evt_total;
	logic [15:0] wake_total;
	logic [31:0] seed;
	logic [31:0] q;
	int n_mismatch;
	int check_count;

	eeec_top u_eeec_top (.CLK(CLK), .RST_N(RST_N), .GENERAL_PINS(pins),
		.SUPPLY_MON(sup), .CAL_ALARM(cal), .USB_WAKE(usb),
		.WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we),
		.WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_REQ(irq), .EVT_REQ(evt),
		.WAKE_REQ(wake));
	eeec_irq_sink u_eeec_irq_sink (.clk(CLK), .rst_n(RST_N), .evt_req(evt),
		.wake_req(wake), .evt_total(evt_total), .wake_total(wake_total));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in q
	task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int k;
		@(posedge CLK);
		req <= '{1'b1, 1'b1, w, a, s, d};
		k = 0;
		do
		begin
			@(posedge CLK);
			k++;
		end
		while (ack !== 1'b1 && k < 16);
		q = rdat;
		req <= '0;
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			$display("[ERR] %0t bus answer missing", $time);
			stop_test();
		end
	endtask

	task set_line(input int i, input int p, input logic v);
		if (i < 16)
			pins[p*16+i] <= v;
		else if (i == 16)
			sup <= v;
		else if (i == 17)
			cal <= v;
		else
			usb <= v;
	endtask

	initial
	begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	initial
	begin
		int i;
		int p;
		logic r;
		logic f;
		logic em;
		logic [15:0] e0;
		logic [15:0] w0;
		RST_N = 1'b0;
		pins = '0;
		sup = 1'b0;
		cal = 1'b0;
		usb = 1'b0;
		req = '0;
		seed = 32'hbe15f0fa;
		n_mismatch = 0;
		check_count = 0;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		for (i = 0; i <= 32; i += 4)
		begin
			wb(1'b0, 8'(i), 4'hf, 32'h0);
			chk(q, 32'h0, "reset value");
		end
		$display("test reset done");
		seed = lfsr(seed);
		wb(1'b1, eeec_pkg::OFF_INT_MASK, 4'hf, seed);
		wb(1'b0, eeec_pkg::OFF_INT_MASK, 4'hf, 32'h0);
		chk(q, seed & 32'h0007ffff, "mask readback");
		wb(1'b1, eeec_pkg::OFF_EVT_MASK, 4'h2, 32'h0007ffff);
		wb(1'b0, eeec_pkg::OFF_EVT_MASK, 4'hf, 32'h0);
		chk(q, 32'h0000ff00, "byte lane");
		$display("test masks done");
		for (i = 0; i < 19; i++)
		begin
			seed = lfsr(seed);
			p = seed[2:0] % 5;
			{em, f, r} = seed[10:8];
			if (i < 2)
				{f, r} = {~1'(i), ~1'(i)};
			if (i < 16)
				wb(1'b1, eeec_pkg::OFF_PORT_SEL0 + 8'(4 * (i / 8)), 4'hf,
					32'(p) << (4 * (i % 8)));
			wb(1'b1, eeec_pkg::OFF_RISE_EN, 4'hf, 32'(r) << i);
			wb(1'b1, eeec_pkg::OFF_FALL_EN, 4'hf, 32'(f) << i);
			wb(1'b1, eeec_pkg::OFF_EVT_MASK, 4'hf, 32'(em) << i);
			wb(1'b1, eeec_pkg::OFF_INT_MASK, 4'hf, 32'h1 << i);
			repeat (6) @(posedge CLK);
			wb(1'b1, eeec_pkg::OFF_PENDING, 4'hf, 32'h0007ffff);
			repeat (2) @(posedge CLK);
			e0 = evt_total;
			w0 = wake_total;
			if (i < 16)
			begin
				set_line(i, (p + 1) % 5, 1'b1);
				repeat (8) @(posedge CLK);
				set_line(i, (p + 1) % 5, 1'b0);
				repeat (8) @(posedge CLK);
			end
			set_line(i, p, 1'b1);
			repeat (8) @(posedge CLK);
			set_line(i, p, 1'b0);
			repeat (8) @(posedge CLK);
			wb(1'b0, eeec_pkg::OFF_PENDING, 4'hf, 32'h0);
			chk(q, 32'(r | f) << i, "pending");
			chk({13'h0, irq}, 32'(r | f) << i, "irq");
			chk(32'(evt_total - e0), 32'(em) * (32'(r) + 32'(f)), "evt");
			chk(32'(wake_total - w0), 32'(r) + 32'(f), "wake");
			wb(1'b1, eeec_pkg::OFF_PENDING, 4'hf, 32'h0007ffff);
			repeat (2) @(posedge CLK);
			chk({13'h0, irq}, 32'h0, "cleared");
		end
		$display("test lines done");
		wb(1'b1, eeec_pkg::OFF_INT_MASK, 4'hf, 32'h0007ffff);
		wb(1'b1, eeec_pkg::OFF_SOFT_TRIG, 4'hf, 32'h00000020);
		wb(1'b0, eeec_pkg::OFF_SOFT_TRIG, 4'hf, 32'h0);
		chk(q, 32'h0, "soft reads zero");
		wb(1'b0, eeec_pkg::OFF_PENDING, 4'hf, 32'h0);
		chk(q, 32'h00000020, "soft pending");
		// Port choice 5 selects no pin: line 0 stays low
		wb(1'b1, eeec_pkg::OFF_PORT_SEL0, 4'hf, 32'h00000005);
		wb(1'b1, eeec_pkg::OFF_RISE_EN, 4'hf, 32'h00000001);
		wb(1'b1, eeec_pkg::OFF_PENDING, 4'hf, 32'h0007ffff);
		for (p = 0; p < 5; p++)
			set_line(0, p, 1'b1);
		repeat (8) @(posedge CLK);
		wb(1'b0, eeec_pkg::OFF_PENDING, 4'hf, 32'h0);
		chk(q, 32'h0, "no port");
		for (p = 0; p < 5; p++)
			set_line(0, p, 1'b0);
		repeat (8) @(posedge CLK);
		wb(1'b1, eeec_pkg::OFF_RISE_EN, 4'hf, 32'h00010000);
		repeat (4) @(posedge CLK);
		// Pulse far shorter than a clock period
		#3 sup = 1'b1;
		#6 sup = 1'b0;
		repeat (8) @(posedge CLK);
		wb(1'b0, eeec_pkg::OFF_PENDING, 4'hf, 32'h0);
		chk(q, 32'h00010000, "short pulse");
		$display("test soft, port range and short pulse done");
		stop_test();
	end
endmodule
